// ==== include/pcp_pkg.sv ====
// shared constants and types of the config-protect-preload block
package pcp_pkg;
	// -----------------------------------------------------------------
	// register byte offsets
	// -----------------------------------------------------------------
	localparam logic [7:0] PCP_OFF_CTRL = 8'h00;
	localparam logic [7:0] PCP_OFF_STATUS = 8'h04;
	localparam logic [7:0] PCP_OFF_ARR_ADDR = 8'h08;
	localparam logic [7:0] PCP_OFF_ARR_DATA = 8'h0C;
	localparam logic [7:0] PCP_OFF_SIG_LO = 8'h10;
	localparam logic [7:0] PCP_OFF_SIG_HI = 8'h14;
	localparam logic [7:0] PCP_OFF_CSUM = 8'h18;
	localparam logic [7:0] PCP_OFF_PRELOAD = 8'h1C;
	localparam logic [7:0] PCP_OFF_STATE = 8'h20;
	// -----------------------------------------------------------------
	// field positions
	// -----------------------------------------------------------------
	localparam int PCP_CTRL_PROG_START = 0;
	localparam int PCP_CTRL_PROG_END = 1;
	localparam int PCP_CTRL_SECURE_SET = 2;
	localparam int PCP_CTRL_PRELOAD_GO = 3;
	localparam int PCP_ST_ERASING = 0;
	localparam int PCP_ST_OPEN = 1;
	localparam int PCP_ST_SECURE = 2;
	localparam int PCP_ST_REFUSED = 3;
	// -----------------------------------------------------------------
	// sizes and reset values
	// -----------------------------------------------------------------
	localparam int PCP_ARR_WORDS = 16;
	localparam int PCP_ADDR_W = 4;
	localparam int PCP_CELLS = 8;
	localparam int PCP_SIG_BITS = 64;
	localparam logic [PCP_ADDR_W-1:0] PCP_ERASE_LAST = 4'hF;
	localparam logic [31:0] PCP_WORD_RST = 32'h0000_0000;
	localparam logic [PCP_SIG_BITS-1:0] PCP_SIG_RST = 64'h0000_0000_0000_0000;
	localparam logic [PCP_CELLS-1:0] PCP_CELLS_RST = 8'h00;

	typedef enum logic [1:0] {
		PCP_LOCKED = 2'b00,
		PCP_ERASE = 2'b01,
		PCP_OPEN = 2'b10
	} pcp_state_t;
endpackage

// ==== include/pcp_mc_if.sv ====
// link between the control core and the registered-output bank
`timescale 1ns/1ns
interface pcp_mc_if;
	import pcp_pkg::*;
	logic ce;
	logic preload_valid;
	logic [PCP_CELLS-1:0] preload_value;
	logic [PCP_CELLS-1:0] and_mask;
	logic [PCP_CELLS-1:0] xor_mask;
	logic [PCP_CELLS-1:0] user_bits;
	logic [PCP_CELLS-1:0] cells;
	modport ctrl (
		output ce, preload_valid, preload_value, and_mask, xor_mask, user_bits,
		input cells
	);
	modport bank (
		input ce, preload_valid, preload_value, and_mask, xor_mask, user_bits,
		output cells
	);
endinterface

// ==== rtl/pcp_cell_bank.sv ====
// registered output cells with synchronous preload
`timescale 1ns/1ns
module pcp_cell_bank (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	pcp_mc_if.bank mc
);
	import pcp_pkg::*;

	logic [PCP_CELLS-1:0] cells_q;
	logic [PCP_CELLS-1:0] cells_d;

	// -----------------------------------------------------------------
	// next state
	// -----------------------------------------------------------------
	always_comb begin
		cells_d = cells_q;
		if (mc.ce) begin
			// preload breaks the feedback path for one edge
			if (mc.preload_valid) begin
				cells_d = mc.preload_value;
			end else begin
				cells_d = (cells_q & mc.and_mask) ^ (mc.user_bits & mc.xor_mask);
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			cells_q <= PCP_CELLS_RST;
		end else begin
			cells_q <= cells_d;
		end
	end

	assign mc.cells = cells_q;

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	property p_preload_forces;
		@(posedge clk_in) disable iff (sys_rst_in)
		(mc.ce && mc.preload_valid) |=> (cells_q == $past(mc.preload_value));
	endproperty
	a_preload_forces: assert property (p_preload_forces)
		else $error("preload value not loaded into cells");
endmodule

// ==== rtl/pcp_top.sv ====
// config store, read protection, auto erase and preload behind an apb slave
//
// What this block does
// - 64-bit user signature, rewritable when programming
// - signature readable whether or not secured
// - checksum covers the signature contents
// - secured array refuses every functional read-back
// - security clears only through full reprogram
// - each programming cycle erases automatically first
// - preload forces each registered output synchronously
`timescale 1ns/1ns
module pcp_top (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic ce_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [pcp_pkg::PCP_CELLS-1:0] user_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	output logic [pcp_pkg::PCP_CELLS-1:0] cells_out
);
	import pcp_pkg::*;

	localparam int ERASE_MAX = PCP_ARR_WORDS;

	pcp_state_t state_q, state_d;
	logic [31:0] arr_q [PCP_ARR_WORDS];
	logic [31:0] arr_d [PCP_ARR_WORDS];
	logic [PCP_SIG_BITS-1:0] sig_q, sig_d;
	logic [PCP_ADDR_W-1:0] addr_q, addr_d;
	logic [PCP_ADDR_W-1:0] erase_q, erase_d;
	logic [PCP_CELLS-1:0] pre_q, pre_d;
	logic secure_q, secure_d;
	logic refused_q, refused_d;
	logic pre_go_q, pre_go_d;
	logic [31:0] csum_q, csum_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	logic acc_setup, acc_done, arr_we;

	pcp_mc_if mc ();

	pcp_cell_bank u_bank (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.mc(mc)
	);

	assign mc.ce = ce_in;
	assign mc.preload_valid = pre_go_q;
	assign mc.preload_value = pre_q;
	assign mc.and_mask = arr_q[0][PCP_CELLS-1:0];
	assign mc.xor_mask = arr_q[1][PCP_CELLS-1:0];
	assign mc.user_bits = user_in;

	// one wait state: answer is prepared in the first access cycle
	assign acc_setup = ce_in && psel_in && penable_in && !pready_q;
	assign acc_done = ce_in && psel_in && penable_in && pready_q;

	// -----------------------------------------------------------------
	// register file, programming sequence and apb answer
	// -----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		arr_d = arr_q;
		sig_d = sig_q;
		addr_d = addr_q;
		erase_d = erase_q;
		pre_d = pre_q;
		secure_d = secure_q;
		refused_d = refused_q;
		pre_go_d = 1'b0;
		prdata_d = prdata_q;
		pready_d = pready_q;
		pslverr_d = pslverr_q;
		arr_we = 1'b0;
		// checksum spans array and signature
		csum_d = sig_q[31:0] + sig_q[63:32];
		for (int i = 0; i < PCP_ARR_WORDS; i++) begin
			csum_d = csum_d + arr_q[i];
		end
		if (!ce_in) begin
			pre_go_d = pre_go_q;
			csum_d = csum_q;
		end else begin
			if (state_q == PCP_ERASE) begin
				// erase walks the array one word per cycle
				arr_d[erase_q] = PCP_WORD_RST;
				arr_we = 1'b1;
				erase_d = erase_q + 1'b1;
				if (erase_q == PCP_ERASE_LAST) begin
					// protection drops only once nothing is left to expose
					secure_d = 1'b0;
					state_d = PCP_OPEN;
				end
			end
			if (acc_setup) begin
				pready_d = 1'b1;
				pslverr_d = 1'b0;
				prdata_d = 32'h0000_0000;
				case (paddr_in)
					PCP_OFF_CTRL: begin
						prdata_d = 32'h0000_0000;
					end
					PCP_OFF_STATUS: begin
						prdata_d[PCP_ST_ERASING] = (state_q == PCP_ERASE);
						prdata_d[PCP_ST_OPEN] = (state_q == PCP_OPEN);
						prdata_d[PCP_ST_SECURE] = secure_q;
						prdata_d[PCP_ST_REFUSED] = refused_q;
					end
					PCP_OFF_ARR_ADDR: begin
						prdata_d[PCP_ADDR_W-1:0] = addr_q;
					end
					PCP_OFF_ARR_DATA: begin
						if (pwrite_in) begin
							pslverr_d = (state_q != PCP_OPEN);
						end else if (secure_q) begin
							pslverr_d = 1'b1;
							refused_d = 1'b1;
						end else begin
							prdata_d = arr_q[addr_q];
						end
					end
					PCP_OFF_SIG_LO: begin
						pslverr_d = pwrite_in && (state_q != PCP_OPEN);
						prdata_d = sig_q[31:0];
					end
					PCP_OFF_SIG_HI: begin
						pslverr_d = pwrite_in && (state_q != PCP_OPEN);
						prdata_d = sig_q[63:32];
					end
					PCP_OFF_CSUM: begin
						pslverr_d = pwrite_in;
						prdata_d = csum_q;
					end
					PCP_OFF_PRELOAD: begin
						prdata_d[PCP_CELLS-1:0] = pre_q;
					end
					PCP_OFF_STATE: begin
						pslverr_d = pwrite_in;
						prdata_d[PCP_CELLS-1:0] = mc.cells;
					end
					default: begin
						pslverr_d = 1'b1;
					end
				endcase
			end
			if (acc_done) begin
				pready_d = 1'b0;
				if (pwrite_in && !pslverr_q) begin
					case (paddr_in)
						PCP_OFF_CTRL: begin
							if (pwdata_in[PCP_CTRL_PROG_START] && state_q != PCP_ERASE) begin
								// every programming cycle starts with an erase
								state_d = PCP_ERASE;
								erase_d = '0;
								sig_d = PCP_SIG_RST;
							end else if (pwdata_in[PCP_CTRL_PROG_END] && state_q == PCP_OPEN) begin
								state_d = PCP_LOCKED;
							end
							if (pwdata_in[PCP_CTRL_SECURE_SET] && state_q == PCP_OPEN) begin
								secure_d = 1'b1;
							end
							pre_go_d = pwdata_in[PCP_CTRL_PRELOAD_GO];
						end
						PCP_OFF_STATUS: begin
							// write one clears; a refusal in the same cycle wins
							if (pwdata_in[PCP_ST_REFUSED] && !refused_d) begin
								refused_d = 1'b0;
							end else if (pwdata_in[PCP_ST_REFUSED] && !(acc_setup && secure_q)) begin
								refused_d = 1'b0;
							end
						end
						PCP_OFF_ARR_ADDR: begin
							addr_d = pwdata_in[PCP_ADDR_W-1:0];
						end
						PCP_OFF_ARR_DATA: begin
							arr_d[addr_q] = pwdata_in;
							arr_we = 1'b1;
						end
						PCP_OFF_SIG_LO: begin
							sig_d[31:0] = pwdata_in;
						end
						PCP_OFF_SIG_HI: begin
							sig_d[63:32] = pwdata_in;
						end
						PCP_OFF_PRELOAD: begin
							pre_d = pwdata_in[PCP_CELLS-1:0];
						end
						default: begin
						end
					endcase
				end
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			state_q <= PCP_LOCKED;
			for (int i = 0; i < PCP_ARR_WORDS; i++) begin
				arr_q[i] <= PCP_WORD_RST;
			end
			sig_q <= PCP_SIG_RST;
			addr_q <= '0;
			erase_q <= '0;
			pre_q <= PCP_CELLS_RST;
			secure_q <= 1'b0;
			refused_q <= 1'b0;
			pre_go_q <= 1'b0;
			csum_q <= PCP_WORD_RST;
			prdata_q <= PCP_WORD_RST;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			state_q <= state_d;
			arr_q <= arr_d;
			sig_q <= sig_d;
			addr_q <= addr_d;
			erase_q <= erase_d;
			pre_q <= pre_d;
			secure_q <= secure_d;
			refused_q <= refused_d;
			pre_go_q <= pre_go_d;
			csum_q <= csum_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign prdata_out = prdata_q;
	assign pready_out = pready_q;
	assign pslverr_out = pslverr_q;
	assign cells_out = mc.cells;

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	property p_sig_write;
		@(posedge clk_in) disable iff (sys_rst_in)
		(acc_done && pwrite_in && !pslverr_q && paddr_in == PCP_OFF_SIG_LO)
		|=> (sig_q[31:0] == $past(pwdata_in));
	endproperty
	a_sig_write: assert property (p_sig_write)
		else $error("signature low word not stored");

	property p_sig_readable;
		@(posedge clk_in) disable iff (sys_rst_in)
		(acc_setup && !pwrite_in && paddr_in == PCP_OFF_SIG_HI)
		|=> (pready_q && !pslverr_q && prdata_q == $past(sig_q[63:32]));
	endproperty
	a_sig_readable: assert property (p_sig_readable)
		else $error("signature read refused or wrong");

	property p_csum_follows_sig;
		@(posedge clk_in) disable iff (sys_rst_in)
		(ce_in && $changed(sig_q) && !$past(arr_we)) |=> (csum_q != $past(csum_q));
	endproperty
	a_csum_follows_sig: assert property (p_csum_follows_sig)
		else $error("checksum unchanged after signature change");

	property p_secure_refuses;
		@(posedge clk_in) disable iff (sys_rst_in)
		(acc_setup && !pwrite_in && secure_q && paddr_in == PCP_OFF_ARR_DATA)
		|=> (pready_q && pslverr_q && prdata_q == 32'h0000_0000 && refused_q);
	endproperty
	a_secure_refuses: assert property (p_secure_refuses)
		else $error("secured array read not refused");

	property p_secure_clear_via_erase;
		@(posedge clk_in) disable iff (sys_rst_in)
		$fell(secure_q) |-> ($past(state_q) == PCP_ERASE && $past(erase_q) == PCP_ERASE_LAST);
	endproperty
	a_secure_clear_via_erase: assert property (p_secure_clear_via_erase)
		else $error("security cleared outside a full erase");

	property p_auto_erase;
		@(posedge clk_in) disable iff (sys_rst_in)
		(acc_done && pwrite_in && !pslverr_q && paddr_in == PCP_OFF_CTRL
			&& pwdata_in[PCP_CTRL_PROG_START] && state_q != PCP_ERASE)
		|=> (state_q == PCP_ERASE) ##[1:ERASE_MAX] (state_q == PCP_OPEN && arr_q[0] == 32'h0000_0000);
	endproperty
	a_auto_erase: assert property (p_auto_erase)
		else $error("programming cycle did not erase");
endmodule

// ==== bench/pcp_programmer.sv ====
// apb programmer model standing on the far side of the config block
`timescale 1ns/1ns
module pcp_programmer (
	input wire logic clk_in,
	input wire logic [31:0] prdata_in,
	input wire logic pready_in,
	input wire logic pslverr_in,
	output logic psel_out,
	output logic penable_out,
	output logic pwrite_out,
	output logic [7:0] paddr_out,
	output logic [31:0] pwdata_out
);
	initial begin
		psel_out = 1'b0;
		penable_out = 1'b0;
		pwrite_out = 1'b0;
		paddr_out = 8'h00;
		pwdata_out = 32'h0000_0000;
	end
	// -----------------------------------------------------------------
	// one transfer, held until pready is seen high at an edge
	// -----------------------------------------------------------------
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clk_in);
		psel_out <= 1'b1;
		penable_out <= 1'b0;
		pwrite_out <= w;
		paddr_out <= a;
		pwdata_out <= d;
		@(posedge clk_in);
		penable_out <= 1'b1;
		// no cycle count assumed: only the bench watchdog ends a hung wait
		do begin
			@(posedge clk_in);
		end while (pready_in !== 1'b1);
		r = prdata_in;
		e = pslverr_in;
		psel_out <= 1'b0;
		penable_out <= 1'b0;
		// released data must not look like a held value
		pwdata_out <= ~d;
	endtask
endmodule

// ==== bench/pcp_top_bench.sv ====
// self-checking bench for the config-protect-preload block
`timescale 1ns/1ns
module pcp_top_bench;
	import pcp_pkg::*;
	logic clk_in;
	logic sys_rst_in;
	logic ce_in;
	logic [7:0] user_in;
	logic psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [PCP_CELLS-1:0] cells;
	int n_fail;
	int num_checks;
	localparam logic [7:0] AND_M = 8'hF0;
	localparam logic [7:0] XOR_M = 8'h0F;

	// next cell state by the bank's feedback rule with the masks loaded below
	function automatic logic [7:0] nxt(input logic [7:0] c);
		return (c & AND_M) ^ (user_in & XOR_M);
	endfunction

	pcp_programmer prog (.clk_in(clk_in), .prdata_in(prdata), .pready_in(pready),
		.pslverr_in(pslverr), .psel_out(psel), .penable_out(penable),
		.pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata));
	pcp_top uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
		.pwdata_in(pwdata), .user_in(user_in), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .cells_out(cells));

	// -----------------------------------------------------------------
	// helpers
	// -----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
		logic e;
		prog.xfer(1'b1, a, d, r, e);
		chk({31'd0, e}, {31'd0, ee}, "write error flag");
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic ee);
		logic e;
		prog.xfer(1'b0, a, 32'h0000_0000, r, e);
		chk({31'd0, e}, {31'd0, ee}, "read error flag");
		chk(r, exp, "read data");
	endtask
	task automatic wait_open();
		logic e;
		int n;
		n = 0;
		do begin
			prog.xfer(1'b0, PCP_OFF_STATUS, 32'h0000_0000, r, e);
			n++;
		end while (r[PCP_ST_OPEN] !== 1'b1 && n < 20);
		chk(r & 32'h0000_0007, 32'h0000_0002, "open, unsecured");
	endtask
	task automatic finish_test();
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// -----------------------------------------------------------------
	// scenarios
	// -----------------------------------------------------------------
	task automatic t_program();
		logic [31:0] sum;
		rd(PCP_OFF_STATUS, 32'h0000_0000, 1'b0);
		wr(PCP_OFF_SIG_LO, 32'h1111_2222, 1'b1);
		wr(PCP_OFF_CTRL, 32'h0000_0001, 1'b0);
		prog.xfer(1'b0, PCP_OFF_STATUS, 32'h0000_0000, r, sum[0]);
		chk({31'd0, r[PCP_ST_ERASING]}, 32'h0000_0001, "erasing");
		wait_open();
		wr(PCP_OFF_ARR_ADDR, 32'h0000_0001, 1'b0);
		wr(PCP_OFF_ARR_DATA, 32'h0000_00FF, 1'b0);
		wr(PCP_OFF_ARR_ADDR, 32'h0000_000F, 1'b0);
		wr(PCP_OFF_ARR_DATA, 32'h1234_5678, 1'b0);
		wr(PCP_OFF_SIG_LO, 32'h0BAD_F00D, 1'b0);
		wr(PCP_OFF_SIG_HI, 32'hDEAD_BEEF, 1'b0);
		rd(PCP_OFF_SIG_HI, 32'hDEAD_BEEF, 1'b0);
		sum = 32'h0000_00FF + 32'h1234_5678 + 32'h0BAD_F00D + 32'hDEAD_BEEF;
		rd(PCP_OFF_CSUM, sum, 1'b0);
		wr(PCP_OFF_SIG_LO, 32'h0BAD_F00E, 1'b0);
		rd(PCP_OFF_CSUM, sum + 32'h0000_0001, 1'b0);
		rd(PCP_OFF_ARR_DATA, 32'h1234_5678, 1'b0);
	endtask
	task automatic t_secure();
		wr(PCP_OFF_CTRL, 32'h0000_0004, 1'b0);
		wr(PCP_OFF_CTRL, 32'h0000_0002, 1'b0);
		rd(PCP_OFF_ARR_DATA, 32'h0000_0000, 1'b1);
		rd(PCP_OFF_STATUS, 32'h0000_000C, 1'b0);
		wr(PCP_OFF_STATUS, 32'h0000_0008, 1'b0);
		rd(PCP_OFF_STATUS, 32'h0000_0004, 1'b0);
		rd(PCP_OFF_SIG_LO, 32'h0BAD_F00E, 1'b0);
		rd(PCP_OFF_SIG_HI, 32'hDEAD_BEEF, 1'b0);
		wr(PCP_OFF_SIG_HI, 32'h0000_0000, 1'b1);
		wr(PCP_OFF_ARR_DATA, 32'h0000_0001, 1'b1);
		rd(PCP_OFF_SIG_HI, 32'hDEAD_BEEF, 1'b0);
		rd(8'h24, 32'h0000_0000, 1'b1);
		wr(PCP_OFF_CSUM, 32'h0000_0001, 1'b1);
		wr(PCP_OFF_STATE, 32'h0000_0001, 1'b1);
	endtask
	task automatic t_reprogram();
		wr(PCP_OFF_CTRL, 32'h0000_0001, 1'b0);
		wait_open();
		rd(PCP_OFF_ARR_DATA, 32'h0000_0000, 1'b0);
		rd(PCP_OFF_CSUM, 32'h0000_0000, 1'b0);
		wr(PCP_OFF_ARR_ADDR, 32'h0000_0000, 1'b0);
		wr(PCP_OFF_ARR_DATA, {24'd0, AND_M}, 1'b0);
		wr(PCP_OFF_ARR_ADDR, 32'h0000_0001, 1'b0);
		wr(PCP_OFF_ARR_DATA, {24'd0, XOR_M}, 1'b0);
	endtask
	// feedback mask makes the next state depend on the forced one
	task automatic t_preload(input logic [7:0] v);
		wr(PCP_OFF_PRELOAD, {24'd0, v}, 1'b0);
		wr(PCP_OFF_CTRL, 32'h0000_0008, 1'b0);
		@(posedge clk_in);
		#1 chk({24'd0, cells}, {24'd0, v}, "preloaded state");
		@(posedge clk_in);
		#1 chk({24'd0, cells}, {24'd0, nxt(v)}, "next state");
	endtask
	// enable low right after the go write: cells and the pending load must wait
	task automatic t_freeze(input logic [7:0] v, input logic [7:0] held);
		wr(PCP_OFF_PRELOAD, {24'd0, v}, 1'b0);
		wr(PCP_OFF_CTRL, 32'h0000_0008, 1'b0);
		ce_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		#1 chk({24'd0, cells}, {24'd0, held}, "cells frozen");
		@(posedge clk_in);
		ce_in <= 1'b1;
		@(posedge clk_in);
		#1 chk({24'd0, cells}, {24'd0, v}, "preload after enable");
	endtask

	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end
	initial begin
		#40000;
		n_fail++;
		finish_test();
	end
	initial begin
		n_fail = 0;
		num_checks = 0;
		sys_rst_in = 1'b1;
		ce_in = 1'b1;
		user_in = 8'h3C;
		repeat (12) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		#1 chk({24'd0, cells}, 32'h0000_0000, "cells after reset");
		t_program();
		t_secure();
		t_reprogram();
		t_preload(8'h00);
		t_preload(8'hFF);
		t_preload(8'h5A);
		t_freeze(8'hA5, nxt(8'h5A));
		rd(PCP_OFF_STATE, {24'd0, nxt(8'hA5)}, 1'b0);
		finish_test();
	end
endmodule
